// *** pkg/pifl_defines.svh ***
// Register offsets, field positions and reset values for the low interrupt flags
`ifndef PIFL_DEFINES_SVH
`define PIFL_DEFINES_SVH

// Register byte offsets
`define PIFL_OFF_FLAGS    4'h0
`define PIFL_OFF_STATUS   4'h4
`define PIFL_OFF_MASK     4'h8
`define PIFL_OFF_PINSEL   4'hc

// Field positions
`define PIFL_BIT_ADC      2
`define PIFL_BIT_ZCD      1
`define PIFL_BIT_EXT0     0
`define PIFL_PINSEL_LSB   0
`define PIFL_PINSEL_MSB   2
`define PIFL_EDGE_BIT     4

// Reset values
`define PIFL_RST_FLAGS    3'h0
`define PIFL_RST_MASK     3'h0
`define PIFL_RST_PINSEL   3'h0
`define PIFL_RST_EDGE     1'h0
`define PIFL_RST_RDATA    8'h00

`endif

// *** pkg/pifl_pkg.sv ***
// Types shared by the low interrupt flag block
`default_nettype none

package pifl_pkg;

    typedef logic [2:0] pifl_flags_t;
    typedef logic [2:0] pifl_pinsel_t;
    typedef logic [7:0] pifl_byte_t;

    typedef enum logic [0:0] {
        PIFL_EDGE_RISE = 1'b0,
        PIFL_EDGE_FALL = 1'b1
    } pifl_edge_t;

endpackage

`default_nettype wire

// *** src/pifl_flags_low.sv ***
// Sticky converter, zero-cross and external pin event flags with register port and interrupt
`default_nettype none
`include "pifl_defines.svh"

module pifl_flags_low
    import pifl_pkg::*;
(
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst,

    // Register port
    input  wire logic [3:0]  i_addr,
    input  wire pifl_byte_t  i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output pifl_byte_t       o_rdata,

    // Event sources
    input  wire logic        i_adc_event,
    input  wire logic        i_zcd_event,
    input  wire logic [7:0]  i_gpio,

    // Flag view and interrupt
    output pifl_flags_t      o_flags,
    output logic             o_irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    ////////////////////////////////////////////////////////////////////////////

    function automatic logic hit(input logic [3:0] addr, input logic [3:0] off);
        hit = (addr == off);
    endfunction

    function automatic pifl_byte_t widen(input pifl_flags_t val);
        widen = {5'h00, val};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State
    ////////////////////////////////////////////////////////////////////////////

    pifl_flags_t  flags;
    pifl_flags_t  mask;
    pifl_pinsel_t ext_pin_select_reg;
    pifl_edge_t   edge_mode;
    pifl_byte_t   rdata;
    logic         irq;

    pifl_flags_t  next_flags;
    pifl_flags_t  next_mask;
    pifl_pinsel_t next_ext_pin_select_reg;
    pifl_edge_t   next_edge_mode;
    pifl_byte_t   next_rdata;
    logic         next_irq;

    pifl_flags_t  set_bits;
    pifl_flags_t  clr_bits;
    logic         ext_event;
    logic         wr_flags;
    logic         wr_status;
    logic         wr_mask;
    logic         wr_pinsel;

    logic         adc_event_flag;
    logic         zero_cross_event_flag;
    logic         ext_pin0_event_flag;

    ////////////////////////////////////////////////////////////////////////////
    // External pin event detector
    ////////////////////////////////////////////////////////////////////////////

    pifl_pin_event u_pin_event (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_gpio  (i_gpio),
        .i_sel   (ext_pin_select_reg),
        .i_edge  (edge_mode),
        .o_event (ext_event)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Event flags
    ////////////////////////////////////////////////////////////////////////////

    // Write strobes per register
    always_comb begin
        wr_flags  = i_wr && hit(i_addr, `PIFL_OFF_FLAGS);
        wr_status = i_wr && hit(i_addr, `PIFL_OFF_STATUS);
        wr_mask   = i_wr && hit(i_addr, `PIFL_OFF_MASK);
        wr_pinsel = i_wr && hit(i_addr, `PIFL_OFF_PINSEL);
    end

    // Set terms ignore mask and any global enable
    always_comb begin
        set_bits                 = 3'h0;
        set_bits[`PIFL_BIT_ADC]  = i_adc_event;
        set_bits[`PIFL_BIT_ZCD]  = i_zcd_event;
        set_bits[`PIFL_BIT_EXT0] = ext_event;
    end

    // Flag register clears by writing 0; status alias clears by writing 1
    always_comb begin
        clr_bits = 3'h0;
        if (wr_flags) begin
            clr_bits = ~i_wdata[2:0];
        end else if (wr_status) begin
            clr_bits = i_wdata[2:0];
        end
    end

    // Set wins over a clear in the same cycle; software can never set
    always_comb begin
        next_flags = (flags & ~clr_bits) | set_bits;
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            flags <= `PIFL_RST_FLAGS;
        end else begin
            flags <= next_flags;
        end
    end

    assign adc_event_flag        = flags[`PIFL_BIT_ADC];
    assign zero_cross_event_flag = flags[`PIFL_BIT_ZCD];
    assign ext_pin0_event_flag   = flags[`PIFL_BIT_EXT0];

    ////////////////////////////////////////////////////////////////////////////
    // Control registers
    ////////////////////////////////////////////////////////////////////////////

    always_comb begin
        next_mask               = mask;
        next_ext_pin_select_reg = ext_pin_select_reg;
        next_edge_mode          = edge_mode;
        if (wr_mask) begin
            next_mask = i_wdata[2:0];
        end
        if (wr_pinsel) begin
            next_ext_pin_select_reg = i_wdata[`PIFL_PINSEL_MSB:`PIFL_PINSEL_LSB];
            next_edge_mode          = pifl_edge_t'(i_wdata[`PIFL_EDGE_BIT]);
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            mask               <= `PIFL_RST_MASK;
            ext_pin_select_reg <= `PIFL_RST_PINSEL;
            edge_mode          <= pifl_edge_t'(`PIFL_RST_EDGE);
        end else begin
            mask               <= next_mask;
            ext_pin_select_reg <= next_ext_pin_select_reg;
            edge_mode          <= next_edge_mode;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port
    ////////////////////////////////////////////////////////////////////////////

    // Data stand only in the cycle after the read strobe
    always_comb begin
        next_rdata = `PIFL_RST_RDATA;
        if (i_rd) begin
            case (i_addr)
                `PIFL_OFF_FLAGS: begin
                    next_rdata = {5'h00, adc_event_flag, zero_cross_event_flag, ext_pin0_event_flag};
                end
                `PIFL_OFF_STATUS: begin
                    next_rdata = widen(flags);
                end
                `PIFL_OFF_MASK: begin
                    next_rdata = widen(mask);
                end
                `PIFL_OFF_PINSEL: begin
                    next_rdata = {3'h0, edge_mode, 1'b0, ext_pin_select_reg};
                end
                default: begin
                    next_rdata = `PIFL_RST_RDATA;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rdata <= `PIFL_RST_RDATA;
        end else begin
            rdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt
    ////////////////////////////////////////////////////////////////////////////

    // Built from next_flags and next_mask, so it rises in the same cycle as the flag
    always_comb begin
        next_irq = |(next_flags & next_mask);
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            irq <= 1'b0;
        end else begin
            irq <= next_irq;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    ////////////////////////////////////////////////////////////////////////////

    assign o_rdata = rdata;
    assign o_flags = flags;
    assign o_irq   = irq;

endmodule // pifl_flags_low

`default_nettype wire

// *** src/pifl_pin_event.sv ***
// External pin selector and edge detector feeding the pin event flag
`default_nettype none
`include "pifl_defines.svh"

module pifl_pin_event
    import pifl_pkg::*;
(
    // Clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    // Pin inputs and selection
    input  wire logic [7:0]   i_gpio,
    input  wire pifl_pinsel_t i_sel,
    input  wire pifl_edge_t   i_edge,
    // Event pulse
    output logic              o_event
);

    logic cur;
    logic prev;
    logic loaded;
    logic armed;
    logic next_cur;
    logic next_prev;
    logic next_loaded;
    logic next_armed;

    // Armed one edge after the first sample, so prev never holds the reset value
    always_comb begin
        next_cur    = i_gpio[i_sel];
        next_prev   = cur;
        next_loaded = 1'b1;
        next_armed  = loaded;
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cur    <= 1'b0;
            prev   <= 1'b0;
            loaded <= 1'b0;
            armed  <= 1'b0;
        end else begin
            cur    <= next_cur;
            prev   <= next_prev;
            loaded <= next_loaded;
            armed  <= next_armed;
        end
    end

    // No event before the first sample pair, so a pin resting high is not an edge
    always_comb begin
        if (i_edge == PIFL_EDGE_FALL) begin
            o_event = armed & prev & ~cur;
        end else begin
            o_event = armed & ~prev & cur;
        end
    end

endmodule // pifl_pin_event

`default_nettype wire

// *** verification/pifl_flags_low_monitor.sv ***
// Port assertions for the low interrupt flag block
`default_nettype none
module pifl_flags_low_monitor
    import pifl_pkg::*;
(
    // Watched ports
    input wire logic        i_clk,
    input wire logic        i_rst,
    input wire logic [3:0]  i_addr,
    input wire pifl_byte_t  i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire pifl_byte_t  o_rdata,
    input wire logic        i_adc_event,
    input wire logic        i_zcd_event,
    input wire logic [7:0]  i_gpio,
    input wire pifl_flags_t o_flags,
    input wire logic        o_irq
);
    // Shadow of mask and pin select, edge mode on top
    logic [2:0] mask;
    logic [3:0] pin;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            mask <= 3'h0;
            pin <= 4'h0;
        end else if (i_wr && i_addr == 4'h8) begin
            mask <= i_wdata[2:0];
        end else if (i_wr && i_addr == 4'hc) begin
            pin <= {i_wdata[4], i_wdata[2:0]};
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence pin_edge_s;
        !$past(i_rst) && $stable(pin) && i_gpio[pin[2:0]] != pin[3] && $past(i_gpio[pin[2:0]]) == pin[3];
    endsequence
    adc_set_a: assert property (i_adc_event |=> o_flags[2])
        else $error("converter flag missed");
    zcd_set_a: assert property (i_zcd_event |=> o_flags[1])
        else $error("zero cross flag missed");
    pin_set_a: assert property (pin_edge_s ##1 $stable(pin) |=> o_flags[0])
        else $error("pin flag missed");
    flags_sticky_a: assert property (!i_wr |=> (o_flags & $past(o_flags)) == $past(o_flags))
        else $error("flag dropped without a write");
    status_clear_a: assert property (i_wr && i_addr == 4'h4 && i_wdata[2] && !i_adc_event |=> !o_flags[2])
        else $error("status clear ignored");
    flags_clear_a: assert property (i_wr && i_addr == 4'h0 && !i_wdata[1] && !i_zcd_event |=> !o_flags[1])
        else $error("flag clear ignored");
    read_flags_a: assert property (i_rd && i_addr == 4'h0 |=> o_rdata == {5'h0, $past(o_flags)})
        else $error("flag read wrong");
    rdata_idle_a: assert property (!i_rd |=> o_rdata == 8'h00)
        else $error("read data not idle");
    irq_level_a: assert property (o_irq == |(o_flags & mask))
        else $error("interrupt level wrong");
endmodule // pifl_flags_low_monitor
bind pifl_flags_low pifl_flags_low_monitor u_mon (.*);
`default_nettype wire

// *** verification/tb.sv ***
// Self-checking bench for the low interrupt flag block
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       i_clk, i_rst, i_wr, i_rd, i_adc_event, i_zcd_event, o_irq, e;
    logic [3:0] i_addr;
    logic [7:0] i_wdata, i_gpio, o_rdata, r;
    logic [2:0] o_flags, f, m;
    logic [8:0] exp_q[$];
    logic       rd_q = 1'b0;
    int         error_cnt = 0, checks = 0, s;
    pifl_flags_low u_dut (
        .i_clk       (i_clk),
        .i_rst       (i_rst),
        .i_addr      (i_addr),
        .i_wdata     (i_wdata),
        .i_wr        (i_wr),
        .i_rd        (i_rd),
        .o_rdata     (o_rdata),
        .i_adc_event (i_adc_event),
        .i_zcd_event (i_zcd_event),
        .i_gpio      (i_gpio),
        .o_flags     (o_flags),
        .o_irq       (o_irq)
    );
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value irq_rdata exp %h seen %h", exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        exp_q.push_back({|(f & m), d});
        @(posedge i_clk);
        i_rd <= 1'b0;
    endtask
    task automatic give_verdict;
        if (exp_q.size() != 0) error_cnt++;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Compares each read answer with the oldest expectation
    always @(posedge i_clk) begin
        if (rd_q) chk({o_irq, o_rdata}, exp_q.pop_front());
        rd_q <= i_rd;
    end
    initial begin
        repeat (5000) @(posedge i_clk);
        error_cnt++;
        give_verdict();
    end
    ////////////////////////////////////////////////////////////
    initial begin
        {i_rst, i_wr, i_rd, i_adc_event, i_zcd_event} = 5'h10;
        {i_addr, i_wdata, i_gpio, f, m} = '0;
        // Selected pin rests high through reset: no edge may follow release
        i_gpio = 8'h01;
        void'($urandom(32'h958c));
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        // Reset values, mapped and unmapped
        for (int a = 0; a < 16; a += 2) rd(a[3:0], 8'h00);
        // Events while everything is masked
        @(posedge i_clk);
        {i_adc_event, i_zcd_event} <= 2'h3;
        @(posedge i_clk);
        {i_adc_event, i_zcd_event} <= 2'h0;
        f = 3'h6;
        rd(4'h4, 8'h06);
        wr(4'h8, 8'h07);
        m = 3'h7;
        rd(4'h0, 8'h06);
        wr(4'h0, 8'h05);
        f = 3'h4;
        rd(4'h0, 8'h04);
        // Status clear in the cycle of a new converter event
        @(posedge i_clk);
        {i_wr, i_addr, i_wdata, i_adc_event} <= {1'b1, 4'h4, 8'h04, 1'b1};
        @(posedge i_clk);
        {i_wr, i_adc_event} <= 2'h0;
        rd(4'h4, 8'h04);
        wr(4'h4, 8'h04);
        f = 3'h0;
        rd(4'h8, 8'h07);
        wr(4'h8, 8'h00);
        m = 3'h0;
        // Clear stale events, then unmask the pin flag
        wr(4'h4, 8'h07);
        wr(4'h8, 8'h01);
        m = 3'h1;
        // Random pin, edge mode alternating, other pins toggling
        for (int i = 0; i < 6; i++) begin
            s = $urandom % 8;
            e = i[0];
            wr(4'hc, {3'h0, e, 1'b0, s[2:0]});
            r = 8'($urandom);
            r[s] = e;
            i_gpio <= r;
            repeat (3) @(posedge i_clk);
            wr(4'h4, 8'h07);
            r = 8'($urandom);
            r[s] = e;
            i_gpio <= r;
            repeat (3) @(posedge i_clk);
            rd(4'h0, 8'h00);
            i_gpio[s] <= ~e;
            repeat (3) @(posedge i_clk);
            f = 3'h1;
            rd(4'h0, 8'h01);
            wr(4'h4, 8'h01);
            f = 3'h0;
        end
        repeat (2) @(posedge i_clk);
        give_verdict();
    end
endmodule // tb
`default_nettype wire
